// ---- inc/ar_pkg.sv ----
// Package for the auto-reclose sequencer: register map, field layout, timing, types.
// Assumes a 100 MHz bus clock and AHB-Lite access with 32-bit words.
package ar_pkg;

    // Clock and timer tick.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    // Request inputs; index 0 has the highest priority.
    localparam int NREQ = 5;
    localparam int REQ_W = 3;

    // Byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam logic [7:0] OFS_SHOT = 8'h40;

    // Control register fields.
    localparam int CTRL_EN = 0;
    localparam int CTRL_RET_FINAL = 1;
    localparam int CTRL_MRST = 2;
    localparam int CTRL_OVR_EN = 3;
    localparam int CTRL_OVR_LSB = 16;

    // Per-request configuration fields.
    localparam int CFG_START_LSB = 0;
    localparam int CFG_ARC_LSB = 16;
    localparam int CFG_ARC_W = 12;
    localparam int CFG_START_MODE = 28;
    localparam int CFG_ARC_EN = 29;

    // Per-shot fields.
    localparam int SHOT_DEAD_LSB = 0;
    localparam int SHOT_RECL_LSB = 16;
    localparam int SHOT_RECL_W = 15;
    localparam int SHOT_EN = 31;

    // Status register fields.
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_RUN = 4;
    localparam int STAT_LOCK = 5;
    localparam int STAT_REQF_LSB = 8;
    localparam int STAT_SHOTF_LSB = 16;

    typedef enum logic [3:0] {
        AR_READY,
        AR_START_WAIT,
        AR_ARC,
        AR_OPEN_WAIT,
        AR_DEAD,
        AR_CLOSE_WAIT,
        OVERALL_RECLAIM_TIMER,
        AR_OVR_RECLAIM,
        AR_FINAL,
        AR_LOCKOUT
    } ar_state_t;

    // Breaker status and acknowledgements from the object-control function.
    typedef struct packed {
        logic is_open;
        logic is_closed;
        logic wait_st;
        logic close_ok;
        logic close_fail;
        logic open_fail;
    } ar_bkr_t;

endpackage

// ---- hdl/ar_sequencer.sv ----
// Multi-shot auto-reclose sequencer with an AHB-Lite register slave.
// Assumes requests, interlocks and breaker status are synchronous to hclk.
//
// Operation
// - An option inserts a fixed arcing delay before a shot opens the breaker.
// - A setting picks next shot or final trip when fault returns during reclaim.
// - Five reclose requests with fixed priority; request one highest.
// - A critical request stops reclosing, issues final trip, enters lock-out.
// - Every request owns its own settings for every shot.
// - A higher-priority request arriving mid-sequence takes over the shot settings.
// - While locked out no breaker close is ever commanded.
// - The sequencer holds while the object waits, until success or failure.
// - Any open or close failure acknowledgement forces lock-out.
// - Lock-out clears on an external reset or on the breaker closing.
// - Trip-driven requests get no start timing; only the trip is watched.
// - A trip-driven request raises running, request-active and first-shot flags.
// - Dead time starts once breaker is open and request released.
// - Dead time expiry sends a close request to the breaker object.
// - The close drops on breaker closed; then the reclaim timer starts.
// - A request returning during reclaim advances to the next available shot.
// - With no shot left, final trip clears running, shot and request flags.
// - After final trip a steady lock-out ignores requests until reset or a fresh breaker close.
// - An interlock input stops the sequence, final trips and locks out.
// - Start-driven requests run the start timer before running and opening.
// - Timers set to zero are skipped.
// - Optional overall reclaim after success; fault then means final trip.
`timescale 1ns/1ns
module ar_sequencer
    import ar_pkg::*;
#(
    parameter int NSHOT = 2,
    parameter int TICK_CYC = TICK_CYC_DEF
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Protection side
    input wire logic [NREQ-1:0] reclose_request,
    input wire logic crit_req,
    input wire logic interlock,
    input wire logic ext_reset,
    // Breaker object side
    input wire ar_bkr_t bkr,
    output logic open_cmd,
    output logic close_cmd,
    output logic final_trip,
    // Status
    output logic recloser_running_flag,
    output logic [NREQ-1:0] request_active_flag,
    output logic [NSHOT-1:0] shot_running_flag,
    output logic lockout_state,
    output ar_state_t seq_state,
    output logic state_event
);

    localparam int SHW = (NSHOT > 1) ? $clog2(NSHOT) : 1;
    localparam int TW = $clog2(TICK_CYC + 1);

    // Refused at elaboration: the shot index and one-hot flags are sized for 1..8 shots.
    if (NSHOT < 1 || NSHOT > 8 || TICK_CYC < 1) begin
        $error("ar_sequencer: NSHOT must be 1..8 and TICK_CYC at least 1");
    end

    typedef struct packed {
        ar_state_t st;
        logic [REQ_W-1:0] req;
        logic [SHW-1:0] shot;
        logic own_open;
        logic [TIMER_W-1:0] tmr;
        logic [TW-1:0] pre;
        logic tick;
        logic closed_d;
        logic mrst;
        logic [31:0] ctrl;
        logic [NREQ-1:0][31:0] cfg;
        logic [NREQ*NSHOT-1:0][31:0] shots;
        logic wr_pend;
        logic wa_ok;
        logic [7:0] wa;
        logic [31:0] rdata;
        logic rdy;
        logic open;
        logic close;
        logic ftrip;
        logic run;
        logic [NREQ-1:0] reqf;
        logic [NSHOT-1:0] shotf;
        logic lock;
        logic evt;
    } ar_regs_t;

    ar_regs_t s;
    ar_regs_t n;

    logic [REQ_W-1:0] hi;
    logic any_req;
    logic [NSHOT-1:0] hi_en;
    logic [SHW:0] nxt;
    logic [31:0] ccfg;
    logic [31:0] cshot;
    logic expired;
    logic addr_ph;
    int ra;

    function automatic int sidx(input logic [REQ_W-1:0] r, input logic [SHW-1:0] sh);
        return int'(r) * NSHOT + int'(sh);
    endfunction

    // Lowest enabled shot above cur; the top bit flags that one was found.
    function automatic logic [SHW:0] next_shot(input logic [NSHOT-1:0] en,
                                               input logic [SHW-1:0] cur);
        logic [SHW:0] r;
        r = '0;
        for (int i = NSHOT - 1; i >= 0; i--) begin
            if (i > int'(cur) && en[i]) begin
                r = {1'b1, SHW'(i)};
            end
        end
        return r;
    endfunction

    // Arcing delay first if enabled; the sequencer opens the breaker itself unless the
    // protection stage's own trip does it.
    function automatic ar_state_t open_phase(input logic [31:0] c);
        return c[CFG_ARC_EN] ? AR_ARC : AR_OPEN_WAIT;
    endfunction

    always_comb begin
        n = s;
        hi = '0;
        any_req = |reclose_request;
        hi_en = '0;
        nxt = '0;
        ra = 0;
        addr_ph = hsel && hready && htrans[1];
        n.rdy = 1'b1;
        n.mrst = 1'b0;

        for (int i = NREQ - 1; i >= 0; i--) begin
            if (reclose_request[i]) begin
                hi = REQ_W'(i);
            end
        end
        for (int i = 0; i < NSHOT; i++) begin
            hi_en[i] = s.shots[sidx(hi, SHW'(0)) + i][SHOT_EN];
        end

        // Tick prescaler shared by every sequence timer.
        if (s.pre == TW'(TICK_CYC - 1)) begin
            n.pre = '0;
            n.tick = 1'b1;
        end else begin
            n.pre = s.pre + 1'b1;
            n.tick = 1'b0;
        end
        n.closed_d = bkr.is_closed;

        // Register writes land in the data phase; unmapped writes are dropped.
        if (s.wr_pend && s.wa_ok) begin
            if (s.wa == OFS_CTRL) begin
                n.ctrl = hwdata;
                n.ctrl[CTRL_MRST] = 1'b0;
                n.mrst = hwdata[CTRL_MRST];
            end else if (s.wa >= OFS_CFG && s.wa < OFS_CFG + 8'(4 * NREQ)) begin
                n.cfg[int'(s.wa[7:2] - OFS_CFG[7:2])] = hwdata;
            end else if (s.wa >= OFS_SHOT && s.wa < OFS_SHOT + 8'(4 * NREQ * NSHOT)) begin
                n.shots[int'(s.wa[7:2] - OFS_SHOT[7:2])] = hwdata;
            end
        end
        n.wr_pend = addr_ph && hwrite;
        n.wa = haddr[7:0];
        n.wa_ok = (haddr[31:8] == 24'h0);

        // Read data is fetched in the address phase and presented in the data phase.
        if (addr_ph && !hwrite) begin
            n.rdata = 32'h0;
            if (haddr[31:8] == 24'h0) begin
                if (haddr[7:0] == OFS_CTRL) begin
                    n.rdata = s.ctrl;
                end else if (haddr[7:0] == OFS_STAT) begin
                    n.rdata[STAT_STATE_LSB +: 4] = s.st;
                    n.rdata[STAT_RUN] = s.run;
                    n.rdata[STAT_LOCK] = s.lock;
                    n.rdata[STAT_REQF_LSB +: NREQ] = s.reqf;
                    n.rdata[STAT_SHOTF_LSB +: NSHOT] = s.shotf;
                end else if (haddr[7:0] >= OFS_CFG && haddr[7:0] < OFS_CFG + 8'(4 * NREQ)) begin
                    ra = int'(haddr[7:2] - OFS_CFG[7:2]);
                    n.rdata = s.cfg[ra];
                end else if (haddr[7:0] >= OFS_SHOT &&
                             haddr[7:0] < OFS_SHOT + 8'(4 * NREQ * NSHOT)) begin
                    ra = int'(haddr[7:2] - OFS_SHOT[7:2]);
                    n.rdata = s.shots[ra];
                end
            end
        end

        // Timer runs down on ticks; a zero setting expires at once and is skipped.
        expired = (s.tmr == '0);
        if (s.tick && !expired) begin
            n.tmr = s.tmr - 1'b1;
        end

        // A higher-priority request takes over the remaining shots.
        if (any_req && hi < s.req && s.st != AR_READY && s.st != AR_FINAL &&
            s.st != AR_LOCKOUT && s.st != AR_OVR_RECLAIM) begin
            n.req = hi;
            n.reqf = NREQ'(1) << hi;
        end
        ccfg = s.cfg[n.req];
        cshot = s.shots[sidx(n.req, s.shot)];

        case (s.st)
            AR_READY: begin
                if (any_req && s.ctrl[CTRL_EN] && hi_en[0]) begin
                    n.req = hi;
                    n.shot = '0;
                    n.reqf = NREQ'(1) << hi;
                    n.shotf = NSHOT'(1);
                    if (s.cfg[hi][CFG_START_MODE]) begin
                        n.st = AR_START_WAIT;
                        n.tmr = s.cfg[hi][CFG_START_LSB +: TIMER_W];
                    end else begin
                        n.run = 1'b1;
                        n.st = open_phase(s.cfg[hi]);
                        n.own_open = s.cfg[hi][CFG_ARC_EN];
                        n.tmr = TIMER_W'(s.cfg[hi][CFG_ARC_LSB +: CFG_ARC_W]);
                    end
                end
            end
            AR_START_WAIT: begin
                if (!reclose_request[s.req]) begin
                    n.st = AR_READY;
                end else if (expired) begin
                    n.run = 1'b1;
                    n.own_open = 1'b1;
                    n.st = open_phase(ccfg);
                    n.tmr = TIMER_W'(ccfg[CFG_ARC_LSB +: CFG_ARC_W]);
                end
            end
            AR_ARC: begin
                if (expired) begin
                    n.st = AR_OPEN_WAIT;
                end
            end
            AR_OPEN_WAIT: begin
                if (bkr.open_fail) begin
                    n.st = AR_FINAL;
                end else if (bkr.is_open && !reclose_request[n.req]) begin
                    n.st = AR_DEAD;
                    n.tmr = cshot[SHOT_DEAD_LSB +: TIMER_W];
                end
            end
            AR_DEAD: begin
                if (expired) begin
                    n.st = AR_CLOSE_WAIT;
                end
            end
            AR_CLOSE_WAIT: begin
                // A waiting object (not ready, synchronism pending) just holds us here.
                if (bkr.close_fail) begin
                    n.st = AR_FINAL;
                end else if (bkr.is_closed || bkr.close_ok) begin
                    n.st = OVERALL_RECLAIM_TIMER;
                    n.tmr = TIMER_W'(cshot[SHOT_RECL_LSB +: SHOT_RECL_W]);
                end
            end
            OVERALL_RECLAIM_TIMER: begin
                if (any_req) begin
                    nxt = next_shot(hi_en, s.shot);
                    if (s.ctrl[CTRL_RET_FINAL] || !nxt[SHW]) begin
                        n.st = AR_FINAL;
                    end else begin
                        n.req = hi;
                        n.reqf = NREQ'(1) << hi;
                        n.shot = nxt[SHW-1:0];
                        n.shotf = NSHOT'(1) << nxt[SHW-1:0];
                        if (s.cfg[hi][CFG_START_MODE]) begin
                            n.st = AR_START_WAIT;
                            n.tmr = s.cfg[hi][CFG_START_LSB +: TIMER_W];
                        end else begin
                            n.st = open_phase(s.cfg[hi]);
                            n.own_open = s.cfg[hi][CFG_ARC_EN];
                            n.tmr = TIMER_W'(s.cfg[hi][CFG_ARC_LSB +: CFG_ARC_W]);
                        end
                    end
                end else if (expired) begin
                    if (s.ctrl[CTRL_OVR_EN]) begin
                        n.st = AR_OVR_RECLAIM;
                        n.tmr = s.ctrl[CTRL_OVR_LSB +: TIMER_W];
                    end else begin
                        n.st = AR_READY;
                    end
                end
            end
            AR_OVR_RECLAIM: begin
                if (any_req) begin
                    n.st = AR_FINAL;
                end else if (expired) begin
                    n.st = AR_READY;
                end
            end
            AR_FINAL: begin
                n.st = AR_LOCKOUT;
            end
            AR_LOCKOUT: begin
                // Requests are ignored here; only a reset or a fresh close releases it.
                if (ext_reset || s.mrst || (bkr.is_closed && !s.closed_d)) begin
                    n.st = AR_READY;
                end
            end
            default: begin
                n.st = AR_READY;
            end
        endcase

        // Critical request, interlock and failures outrank every sequence step.
        if ((crit_req || interlock || bkr.open_fail || bkr.close_fail) &&
            s.st != AR_FINAL && s.st != AR_LOCKOUT) begin
            n.st = AR_FINAL;
        end

        // Flags drop whenever no sequence is in progress.
        if (n.st == AR_READY || n.st == AR_FINAL || n.st == AR_LOCKOUT ||
            n.st == AR_OVR_RECLAIM) begin
            n.run = 1'b0;
            n.reqf = '0;
            n.shotf = '0;
            n.own_open = 1'b0;
        end
        n.open = (n.st == AR_OPEN_WAIT && n.own_open) || n.st == AR_FINAL;
        n.close = (n.st == AR_CLOSE_WAIT) && !bkr.is_closed;
        n.ftrip = (n.st == AR_FINAL);
        n.lock = (n.st == AR_FINAL || n.st == AR_LOCKOUT);
        n.evt = (n.st != s.st);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign hrdata = s.rdata;
    assign hreadyout = s.rdy;
    assign hresp = 1'b0;
    assign open_cmd = s.open;
    assign close_cmd = s.close;
    assign final_trip = s.ftrip;
    assign recloser_running_flag = s.run;
    assign request_active_flag = s.reqf;
    assign shot_running_flag = s.shotf;
    assign lockout_state = s.lock;
    assign seq_state = s.st;
    assign state_event = s.evt;

endmodule

// ---- dv/ar_sequencer_chk.sv ----
// Concurrent checks on the auto-reclose sequencer ports.
// Assumes one hclk domain and that the bus manual reset bit stays unused.
`timescale 1ns/1ns
module ar_sequencer_chk
    import ar_pkg::*;
#(
    parameter int NSHOT = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Stimuli
    input wire logic crit_req,
    input wire logic interlock,
    input wire logic ext_reset,
    input wire ar_bkr_t bkr,
    // Outputs
    input wire logic close_cmd,
    input wire logic final_trip,
    input wire logic recloser_running_flag,
    input wire logic [NREQ-1:0] request_active_flag,
    input wire logic [NSHOT-1:0] shot_running_flag,
    input wire logic lockout_state,
    input wire ar_state_t seq_state,
    input wire logic state_event
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic act;
    logic fail_ack;
    logic abort;
    // An abort in an idle or locked state has nothing to stop.
    assign act = !(seq_state inside {AR_READY, AR_FINAL, AR_LOCKOUT});
    assign fail_ack = bkr.close_fail | bkr.open_fail;
    assign abort = crit_req | interlock | fail_ack;

    a_crit_final: assert property (act && crit_req |=> final_trip)
        else $error("critical request gave no final trip");
    a_ilock_final: assert property (act && interlock |=> final_trip)
        else $error("interlock gave no final trip");
    a_fail_final: assert property (act && fail_ack |=> final_trip)
        else $error("failure ack gave no final trip");
    a_final_clear: assert property (final_trip |-> (!recloser_running_flag
        && request_active_flag == '0 && shot_running_flag == '0)
        ##1 (seq_state == AR_LOCKOUT && !final_trip))
        else $error("final trip flags or lock-out wrong");
    a_lock_noclose: assert property (lockout_state |-> !close_cmd)
        else $error("close commanded while locked");
    a_lock_hold: assert property (seq_state == AR_LOCKOUT && !ext_reset
        && !$rose(bkr.is_closed) |=> seq_state == AR_LOCKOUT)
        else $error("lock-out left without reset");
    a_lock_clear: assert property (seq_state == AR_LOCKOUT && ext_reset
        |=> seq_state == AR_READY)
        else $error("reset did not clear lock-out");
    a_close_hold: assert property (seq_state == AR_CLOSE_WAIT && !abort
        && !bkr.is_closed && !bkr.close_ok |=> seq_state == AR_CLOSE_WAIT)
        else $error("close wait left early");
    a_closed_recl: assert property (seq_state == AR_CLOSE_WAIT && !abort
        && bkr.is_closed |=> seq_state == OVERALL_RECLAIM_TIMER && !close_cmd)
        else $error("no reclaim after breaker closed");
    a_state_event: assert property (state_event == !$stable(seq_state))
        else $error("state event mismatch");

    cover property (final_trip);
    cover property ($rose(shot_running_flag[NSHOT-1]));
    cover property (bkr.wait_st && seq_state == AR_CLOSE_WAIT);
endmodule

bind ar_sequencer ar_sequencer_chk #(.NSHOT(NSHOT)) ar_sequencer_chk_i (
    .hclk(hclk), .hresetn(hresetn), .crit_req(crit_req), .interlock(interlock),
    .ext_reset(ext_reset), .bkr(bkr), .close_cmd(close_cmd), .final_trip(final_trip),
    .recloser_running_flag(recloser_running_flag),
    .request_active_flag(request_active_flag), .shot_running_flag(shot_running_flag),
    .lockout_state(lockout_state), .seq_state(seq_state), .state_event(state_event)
);

// ---- dv/ar_bkr_model.sv ----
// Behavioural breaker object-control function facing the sequencer.
// Assumes the bench stands in for the protection trip and a hand close.
`timescale 1ns/1ns
module ar_bkr_model
    import ar_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Commands
    input wire logic open_cmd,
    input wire logic close_cmd,
    input wire logic prot_open,
    input wire logic hand_close,
    // Behaviour selects
    input wire logic slow,
    input wire logic fail,
    // Status
    output ar_bkr_t bkr
);
    logic [4:0] wait_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bkr <= '{is_closed: 1'b1, default: 1'b0};
            wait_q <= 5'h0;
        end else begin
            bkr.close_ok <= 1'b0;
            bkr.close_fail <= 1'b0;
            if (open_cmd || prot_open) begin
                bkr.is_open <= 1'b1;
                bkr.is_closed <= 1'b0;
            end else if ((close_cmd || hand_close) && !bkr.is_closed) begin
                // A slow close stands in for a pending synchronism permission.
                if (wait_q < (slow ? 5'h14 : 5'h02)) begin
                    wait_q <= wait_q + 5'h1;
                    bkr.wait_st <= 1'b1;
                end else begin
                    wait_q <= 5'h0;
                    bkr.wait_st <= 1'b0;
                    bkr.close_fail <= fail;
                    bkr.close_ok <= !fail;
                    bkr.is_closed <= !fail;
                    bkr.is_open <= fail;
                end
            end
        end
    end
endmodule

// ---- dv/ar_sequencer_test.sv ----
// Self-checking bench for the sequencer: AHB-Lite setup, then reclose runs.
// Assumes the breaker model is the only object on the far side.
`timescale 1ns/1ns
module ar_sequencer_test;
    import ar_pkg::*;
    localparam int TK = 4;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = 2'b00;
    logic [NREQ-1:0] req = '0, reqf;
    logic crit = 1'b0, ilock = 1'b0, xrst = 1'b0, prot_open = 1'b0;
    logic hand_close = 1'b0, slow = 1'b0, fail = 1'b0;
    logic hreadyout, hresp, open_cmd, close_cmd, final_trip, run, lock, ev;
    logic [1:0] shotf;
    ar_state_t st;
    ar_bkr_t bkr;
    int fails = 0;
    int checks_done = 0;

    ar_sequencer #(.NSHOT(2), .TICK_CYC(TK)) ar_sequencer_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reclose_request(req),
        .crit_req(crit), .interlock(ilock), .ext_reset(xrst), .bkr(bkr),
        .open_cmd(open_cmd), .close_cmd(close_cmd), .final_trip(final_trip),
        .recloser_running_flag(run), .request_active_flag(reqf),
        .shot_running_flag(shotf), .lockout_state(lock), .seq_state(st), .state_event(ev)
    );
    ar_bkr_model ar_bkr_model_i (
        .hclk(hclk), .hresetn(hresetn), .open_cmd(open_cmd), .close_cmd(close_cmd),
        .prot_open(prot_open), .hand_close(hand_close), .slow(slow), .fail(fail), .bkr(bkr)
    );

    always #5 hclk = ~hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks_done %0d, fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Address phase and data phase are each held until hready is sampled high.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, exp, "register read");
        chk(32'(hresp), 32'h0, "response");
    endtask

    // Every programmed shot is enabled with a reclaim of five ticks.
    task automatic prog(input int r, input int s, input logic [15:0] dead);
        logic [31:0] v;
        bus(1'b1, 8'(8'h40 + 4 * (r * 2 + s)), 32'h8005_0000 | 32'(dead), v);
    endtask

    task automatic wait_for(input ar_state_t s, input int lim);
        int n;
        n = 0;
        while (st !== s && n < lim) begin
            @(posedge hclk);
            n++;
        end
        chk(32'(st), 32'(s), "state");
    endtask

    // The protection opens the breaker and lets go of its request.
    task automatic start(input logic [NREQ-1:0] m);
        @(posedge hclk) req <= m;
        wait_for(AR_OPEN_WAIT, 10);
        @(posedge hclk);
        req <= '0;
        prot_open <= 1'b1;
        @(posedge hclk) prot_open <= 1'b0;
        wait_for(AR_DEAD, 10);
    endtask

    task automatic finish_shot(input int dead);
        int n;
        n = 0;
        while (st === AR_DEAD && n < 200) begin
            @(posedge hclk);
            n++;
        end
        chk(32'(n >= (dead - 1) * TK + 2 && n <= dead * TK + 1), 32'h1, "dead span");
        chk(32'(close_cmd), 32'h1, "close request");
        wait_for(OVERALL_RECLAIM_TIMER, 40);
        chk(32'(close_cmd), 32'h0, "close dropped");
    endtask

    task automatic bclose();
        hand_close <= 1'b1;
        repeat (6) @(posedge hclk);
        hand_close <= 1'b0;
    endtask

    task automatic unlock();
        xrst <= 1'b1;
        @(posedge hclk) xrst <= 1'b0;
        wait_for(AR_READY, 5);
        bclose();
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        $display("MISMATCH at %0t: run did not finish", $time);
        tally_and_finish();
    end

    initial begin
        logic [31:0] v;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(OFS_CTRL, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h1, v);
        prog(1, 0, 3);
        prog(1, 1, 2);
        prog(3, 0, 6);
        rd_chk(8'h48, 32'h8005_0003);
        rd_chk(8'hf0, 32'h0);
        $display("test setup done");
        start(5'b00010);
        chk(32'({run, reqf, shotf}), 32'h89, "first shot flags");
        finish_shot(3);
        start(5'b00010);
        chk(32'(shotf), 32'h2, "second shot flag");
        finish_shot(2);
        @(posedge hclk) req <= 5'b00010;
        wait_for(AR_LOCKOUT, 10);
        chk(32'({run, reqf, shotf, lock}), 32'h1, "final flags");
        repeat (20) @(posedge hclk);
        rd_chk(OFS_STAT, 32'h29);
        req <= '0;
        unlock();
        $display("test two shots fail done");
        slow <= 1'b1;
        @(posedge hclk) req <= 5'b01000;
        wait_for(AR_OPEN_WAIT, 10);
        start(5'b01010);
        chk(32'(reqf), 32'h2, "higher request takes over");
        finish_shot(3);
        wait_for(AR_READY, 60);
        chk(32'({run, reqf, shotf}), 32'h0, "flags after reclaim");
        slow <= 1'b0;
        $display("test takeover done");
        start(5'b11000);
        chk(32'(reqf), 32'h8, "priority");
        crit <= 1'b1;
        @(posedge hclk) crit <= 1'b0;
        wait_for(AR_LOCKOUT, 5);
        bclose();
        wait_for(AR_READY, 5);
        $display("test critical done");
        fail <= 1'b1;
        start(5'b00010);
        wait_for(AR_LOCKOUT, 60);
        fail <= 1'b0;
        unlock();
        $display("test close failure done");
        start(5'b00010);
        finish_shot(3);
        ilock <= 1'b1;
        @(posedge hclk) ilock <= 1'b0;
        wait_for(AR_LOCKOUT, 5);
        unlock();
        $display("test interlock done");
        bus(1'b1, OFS_CTRL, 32'h3, v);
        start(5'b00010);
        finish_shot(3);
        @(posedge hclk) req <= 5'b00010;
        wait_for(AR_LOCKOUT, 10);
        req <= '0;
        $display("test return final done");
        unlock();
        bus(1'b1, OFS_CTRL, 32'h0003_0009, v);
        bus(1'b1, OFS_CFG, 32'h3002_0002, v);
        prog(0, 0, 3);
        @(posedge hclk) req <= 5'b00001;
        wait_for(AR_START_WAIT, 5);
        chk(32'({run, shotf, open_cmd}), 32'h2, "start wait flags");
        wait_for(AR_ARC, 20);
        chk(32'(run), 32'h1, "running after start time");
        wait_for(AR_OPEN_WAIT, 20);
        chk(32'({run, open_cmd}), 32'h3, "own open command");
        @(posedge hclk) req <= '0;
        wait_for(AR_DEAD, 10);
        finish_shot(3);
        wait_for(AR_OVR_RECLAIM, 30);
        chk(32'({run, reqf, shotf}), 32'h0, "flags in overall reclaim");
        wait_for(AR_READY, 20);
        $display("test start mode done");
        tally_and_finish();
    end
endmodule
